// ---- hpsc_pkg.sv ----
// Package for the slot control register block: offsets, fields, types
package hpsc_pkg;
    // Register byte addresses
    localparam logic [7:0] OFF_SLOT_CTL = 8'hD8;
    localparam logic [7:0] OFF_IRQ_STAT = 8'hE0;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hE4;

    // Slot control field positions
    localparam int BIT_BTN_EN = 0;
    localparam int BIT_PF_EN = 1;
    localparam int BIT_PD_EN = 3;
    localparam int BIT_CC_EN = 4;
    localparam int BIT_HPINT_EN = 5;
    localparam int BIT_ATTN_LO = 6;
    localparam int BIT_PIND_LO = 8;
    localparam int BIT_PWR_OFF = 10;
    localparam int BIT_DLL_EN = 12;
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;

    // Event and status bit positions
    localparam int EVT_N = 5;
    localparam int EVT_BTN = 0;
    localparam int EVT_PF = 1;
    localparam int EVT_PD = 2;
    localparam int EVT_CC = 3;
    localparam int EVT_DLL = 4;

    // Reset values and constant masks
    localparam logic [EVT_N-1:0] STAT_RESET = 5'h00;
    localparam logic [EVT_N-1:0] MASK_RESET = 5'h1F;
    localparam logic [EVT_N-1:0] WAKE_EVTS = 5'h17;
    localparam logic [15:0] SLOT_USED = 16'h17FB;
    localparam logic LINK_ACT_RPT = 1'b1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Indicator field encodings
    typedef enum logic [1:0] {
        IND_RSVD = 2'h0,
        IND_ON = 2'h1,
        IND_BLINK = 2'h2,
        IND_OFF = 2'h3
    } hpsc_ind_t;

    typedef struct packed {
        logic dllChg;
        logic cmdDone;
        logic presChg;
        logic pwrFault;
        logic btnPress;
    } hpsc_evt_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } hpsc_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hpsc_axil_rsp_t;
endpackage

// ---- hpsc_indicator.sv ----
// One slot indicator: field state and message pulse on each write of a non-reserved code
module hpsc_indicator
    import hpsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [1:0] wrVal,
    output hpsc_ind_t state,
    output logic msgValid
);
    typedef struct packed {
        hpsc_ind_t state;
        logic msgValid;
    } hpsc_ind_st_t;

    hpsc_ind_st_t s;
    hpsc_ind_st_t next_s;

    // Reserved code is dropped so the lamp never sits in an undefined state
    always_comb begin
        next_s = s;
        next_s.msgValid = 1'b0;
        if (wrEn && (wrVal != IND_RSVD)) begin
            next_s.state = hpsc_ind_t'(wrVal);
            next_s.msgValid = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= '{state: IND_OFF, msgValid: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign state = s.state;
    assign msgValid = s.msgValid;
endmodule

// ---- hpsc_axil_slave.sv ----
// AXI4-Lite slave front end: channel handshakes, one write and one read at a time
module hpsc_axil_slave
    import hpsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input hpsc_axil_req_t req,
    output hpsc_axil_rsp_t rsp,
    output logic wrEn,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    output logic rdEn,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);
    typedef struct packed {
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic arHave;
        logic [7:0] arAddr;
        hpsc_axil_rsp_t rsp;
    } hpsc_slv_st_t;

    hpsc_slv_st_t s;
    hpsc_slv_st_t next_s;
    logic doWr;
    logic doRd;

    // Address and data may come in either order; act once both are held
    assign doWr = s.awHave && s.wHave && !s.rsp.bvalid;
    assign doRd = s.arHave && !s.rsp.rvalid;

    always_comb begin
        next_s = s;
        if (req.awvalid && s.rsp.awready) begin
            next_s.awHave = 1'b1;
            next_s.awAddr = req.awaddr;
        end
        if (req.wvalid && s.rsp.wready) begin
            next_s.wHave = 1'b1;
            next_s.wData = req.wdata;
            next_s.wStrb = req.wstrb;
        end
        if (s.rsp.bvalid && req.bready) begin
            next_s.rsp.bvalid = 1'b0;
        end
        if (doWr) begin
            next_s.awHave = 1'b0;
            next_s.wHave = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = wrOk ? RESP_OKAY : RESP_DECERR;
        end
        if (req.arvalid && s.rsp.arready) begin
            next_s.arHave = 1'b1;
            next_s.arAddr = req.araddr;
        end
        if (s.rsp.rvalid && req.rready) begin
            next_s.rsp.rvalid = 1'b0;
        end
        if (doRd) begin
            next_s.arHave = 1'b0;
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rdata = rdOk ? rdData : 32'h0000_0000;
            next_s.rsp.rresp = rdOk ? RESP_OKAY : RESP_DECERR;
        end
        // Each ready only while its own channel holds nothing and no answer waits, so a second request waits
        next_s.rsp.awready = !next_s.awHave && !next_s.rsp.bvalid;
        next_s.rsp.wready = !next_s.wHave && !next_s.rsp.bvalid;
        next_s.rsp.arready = !next_s.arHave && !next_s.rsp.rvalid;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rsp = s.rsp;
    assign wrEn = doWr;
    assign wrAddr = s.awAddr;
    assign wrData = s.wData;
    assign wrStrb = s.wStrb;
    assign rdEn = doRd;
    assign rdAddr = s.arAddr;
endmodule

// ---- hpsc_slot_ctl.sv ----
// Slot control register block of a downstream switch port, with event interrupt
// Operation
// RULE1: Button enable lets press raise interrupt/wake
// RULE2: Fault enable lets power fault raise interrupt/wake
// RULE3: Presence enable lets change raise interrupt/wake
// RULE4: Command-done enable raises interrupt per completion
// RULE5: Master enable gates every hot-plug interrupt
// RULE6: Attention field drives lamp, resets off
// RULE7: Attention field write sends attention message
// RULE8: Power indicator field drives lamp, resets off
// RULE9: Power indicator write sends power message
// RULE10: Power bit one turns slot off
// RULE11: Link-change enable notifies on link-active change
// RULE12: Reserved bits read zero, writes ignored
//
// Our own choice: the AXI4-Lite interface to the registers.
module hpsc_slot_ctl
    import hpsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input hpsc_axil_req_t axiReq,
    output hpsc_axil_rsp_t axiRsp,
    input hpsc_evt_t evt,
    output logic hotplugIrq,
    output logic wakeReq,
    output logic slotPowerOff,
    output hpsc_ind_t attnState,
    output logic attnMsgValid,
    output hpsc_ind_t pwrIndState,
    output logic pwrIndMsgValid
);
    typedef struct packed {
        logic dllEn;
        logic pwrOff;
        logic hpIntEn;
        logic ccEn;
        logic pdEn;
        logic pfEn;
        logic btnEn;
    } hpsc_slot_t;

    typedef struct packed {
        hpsc_slot_t slot;
        logic [EVT_N-1:0] stat;
        logic [EVT_N-1:0] mask;
        logic irq;
        logic wake;
    } hpsc_st_t;

    hpsc_st_t s;
    hpsc_st_t next_s;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    logic rdEn;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic rdOk;
    logic wrSlot;
    logic [15:0] slotRead;
    logic [EVT_N-1:0] evtEn;
    logic [EVT_N-1:0] clrBits;

    hpsc_axil_slave u_bus (
        .mclk(mclk),
        .rstn(rstn),
        .req(axiReq),
        .rsp(axiRsp),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdEn(rdEn),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // Decode; only whole aligned words of the three registers exist
    assign wrSlot = wrEn && (wrAddr == OFF_SLOT_CTL);
    assign wrOk = (wrAddr == OFF_SLOT_CTL) || (wrAddr == OFF_IRQ_STAT)
        || (wrAddr == OFF_IRQ_MASK);
    assign rdOk = (rdAddr == OFF_SLOT_CTL) || (rdAddr == OFF_IRQ_STAT)
        || (rdAddr == OFF_IRQ_MASK);

    // Indicator fields live in their own flops and send one message per write of a non-reserved code
    hpsc_indicator u_attn (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn(wrSlot && wrStrb[LANE_LO]), // RULE7
        .wrVal(wrData[BIT_ATTN_LO +: 2]),
        .state(attnState),
        .msgValid(attnMsgValid)
    );

    hpsc_indicator u_pind (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn(wrSlot && wrStrb[LANE_HI]), // RULE9
        .wrVal(wrData[BIT_PIND_LO +: 2]),
        .state(pwrIndState),
        .msgValid(pwrIndMsgValid)
    );

    // Read image; unnamed bits stay zero
    always_comb begin
        slotRead = 16'h0000; // RULE12
        slotRead[BIT_BTN_EN] = s.slot.btnEn;
        slotRead[BIT_PF_EN] = s.slot.pfEn;
        slotRead[BIT_PD_EN] = s.slot.pdEn;
        slotRead[BIT_CC_EN] = s.slot.ccEn;
        slotRead[BIT_HPINT_EN] = s.slot.hpIntEn;
        slotRead[BIT_ATTN_LO +: 2] = attnState; // RULE6
        slotRead[BIT_PIND_LO +: 2] = pwrIndState; // RULE8
        slotRead[BIT_PWR_OFF] = s.slot.pwrOff;
        slotRead[BIT_DLL_EN] = s.slot.dllEn;
        rdData = 32'h0000_0000;
        if (rdAddr == OFF_SLOT_CTL) begin
            rdData[15:0] = slotRead;
        end else if (rdAddr == OFF_IRQ_STAT) begin
            rdData[EVT_N-1:0] = s.stat;
        end else if (rdAddr == OFF_IRQ_MASK) begin
            rdData[EVT_N-1:0] = s.mask;
        end
    end

    // Per-event enables in status bit order
    assign evtEn = {s.slot.dllEn, s.slot.ccEn, s.slot.pdEn, s.slot.pfEn, s.slot.btnEn};
    assign clrBits = (wrEn && (wrAddr == OFF_IRQ_STAT) && wrStrb[LANE_LO])
        ? wrData[EVT_N-1:0] : STAT_RESET;

    // Register updates, sticky status and interrupt / wake outputs
    always_comb begin
        next_s = s;
        if (wrSlot && wrStrb[LANE_LO]) begin
            next_s.slot.btnEn = wrData[BIT_BTN_EN]; // RULE1
            next_s.slot.pfEn = wrData[BIT_PF_EN]; // RULE2
            next_s.slot.pdEn = wrData[BIT_PD_EN]; // RULE3
            next_s.slot.ccEn = wrData[BIT_CC_EN]; // RULE4
            next_s.slot.hpIntEn = wrData[BIT_HPINT_EN]; // RULE5
        end
        if (wrSlot && wrStrb[LANE_HI]) begin
            next_s.slot.pwrOff = wrData[BIT_PWR_OFF]; // RULE10
            next_s.slot.dllEn = LINK_ACT_RPT && wrData[BIT_DLL_EN]; // RULE11
        end
        if (wrEn && (wrAddr == OFF_IRQ_MASK) && wrStrb[LANE_LO]) begin
            next_s.mask = wrData[EVT_N-1:0];
        end
        // An event in the clearing cycle survives the clear
        next_s.stat = (s.stat & ~clrBits) | evt;
        // Master bit gates the interrupt only, not wake; command completion never wakes
        next_s.irq = s.slot.hpIntEn && |(s.stat & evtEn & s.mask); // RULE4 RULE5
        next_s.wake = |(s.stat & evtEn & WAKE_EVTS); // RULE1 RULE2 RULE3 RULE11
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= '{slot: '0, stat: STAT_RESET, mask: MASK_RESET, irq: 1'b0, wake: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign hotplugIrq = s.irq;
    assign wakeReq = s.wake;
    assign slotPowerOff = s.slot.pwrOff;

    // Checks
    AST_BTN_WAKE: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
        (s.stat[EVT_BTN] && s.slot.btnEn) |=> wakeReq)
        else $error("button event enabled but no wake");
    AST_PF_WAKE: assert property (@(posedge mclk) disable iff (!rstn) // RULE2
        (s.stat[EVT_PF] && s.slot.pfEn) |=> wakeReq)
        else $error("power fault enabled but no wake");
    AST_PD_IRQ: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
        (s.stat[EVT_PD] && s.slot.pdEn && s.slot.hpIntEn && s.mask[EVT_PD]) |=> hotplugIrq)
        else $error("presence change enabled but no interrupt");
    AST_CC_IRQ: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
        (evt.cmdDone && next_s.slot.ccEn && next_s.slot.hpIntEn && next_s.mask[EVT_CC])
        |-> ##2 hotplugIrq)
        else $error("command completion raised no interrupt");
    AST_MASTER_GATE: assert property (@(posedge mclk) disable iff (!rstn) // RULE5
        !s.slot.hpIntEn |=> !hotplugIrq)
        else $error("interrupt without master enable");
    AST_ATTN_LEGAL: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        (wrSlot && wrStrb[LANE_LO] && wrData[BIT_ATTN_LO +: 2] == IND_RSVD)
        |=> $stable(attnState))
        else $error("reserved attention code changed the lamp");
    AST_ATTN_MSG: assert property (@(posedge mclk) disable iff (!rstn) // RULE7
        (wrSlot && wrStrb[LANE_LO] && wrData[BIT_ATTN_LO +: 2] != IND_RSVD)
        |=> attnMsgValid && (attnState == $past(wrData[BIT_ATTN_LO +: 2])) ##1 !attnMsgValid)
        else $error("attention write sent no matching message");
    AST_PIND_LEGAL: assert property (@(posedge mclk) disable iff (!rstn) // RULE8
        pwrIndState != IND_RSVD)
        else $error("power indicator in reserved state");
    AST_PIND_MSG: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
        (wrSlot && wrStrb[LANE_HI] && wrData[BIT_PIND_LO +: 2] != IND_RSVD)
        |=> pwrIndMsgValid && (pwrIndState == $past(wrData[BIT_PIND_LO +: 2])))
        else $error("power indicator write sent no matching message");
    AST_PWR_CTL: assert property (@(posedge mclk) disable iff (!rstn) // RULE10
        (wrSlot && wrStrb[LANE_HI]) |=> slotPowerOff == $past(wrData[BIT_PWR_OFF]))
        else $error("power control bit not applied");
    AST_DLL_WAKE: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
        (s.stat[EVT_DLL] && s.slot.dllEn) |=> wakeReq)
        else $error("link change enabled but no notification");
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
        (rdEn && rdAddr == OFF_SLOT_CTL)
        |=> (axiRsp.rdata & ~{16'h0000, SLOT_USED}) == 32'h0000_0000)
        else $error("reserved slot control bits read nonzero");

    // One access applied per request; channels stay shut while an answer waits
    AST_WR_ONCE: assert property (@(posedge mclk) disable iff (!rstn)
        wrEn
        |=> !wrEn)
        else $error("one write request applied twice");
    AST_RD_ONCE: assert property (@(posedge mclk) disable iff (!rstn)
        rdEn
        |=> !rdEn)
        else $error("one read request answered twice");
    AST_WR_BUSY: assert property (@(posedge mclk) disable iff (!rstn)
        axiRsp.bvalid
        |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write channel open while response pending");
    AST_RD_BUSY: assert property (@(posedge mclk) disable iff (!rstn)
        axiRsp.rvalid
        |-> !axiRsp.arready)
        else $error("read channel open while data pending");
    AST_WR_ANSWER: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
        wrEn
        |=> axiRsp.bvalid && (axiRsp.bresp == RESP_OKAY) == $past(wrOk))
        else $error("write answer missing or wrong code");
    AST_RD_ANSWER: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
        rdEn
        |=> axiRsp.rvalid && (axiRsp.rresp == RESP_OKAY) == $past(rdOk))
        else $error("read answer missing or wrong code");

    // A refused write must leave every field and lamp untouched
    AST_BAD_WR_IGNORED: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
        (wrEn && !wrOk)
        |=> $stable(s.slot) && $stable(s.mask) && !attnMsgValid && !pwrIndMsgValid)
        else $error("refused write changed a register");

    // Status is sticky and an event beats a clear in the same cycle
    AST_STAT_KEEP: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
        (~s.stat & $past(s.stat)
        & ~$past(clrBits)) == '0)
        else $error("status bit lost without a clear");
    AST_EVT_SETS: assert property (@(posedge mclk) disable iff (!rstn) // RULE1 RULE2 RULE3 RULE4 RULE11
        $past(rstn)
        |-> (s.stat & $past(evt)) == $past(evt))
        else $error("event did not set its status bit");

    // Outputs stay quiet without an enabled pending event
    AST_IRQ_NEEDS_EVT: assert property (@(posedge mclk) disable iff (!rstn) // RULE1 RULE2 RULE3 RULE4 RULE11
        !(|(s.stat & evtEn & s.mask))
        |=> !hotplugIrq)
        else $error("interrupt without enabled event");
    AST_WAKE_NEEDS_EVT: assert property (@(posedge mclk) disable iff (!rstn) // RULE1 RULE2 RULE3 RULE11
        !(|(s.stat & evtEn & WAKE_EVTS))
        |=> !wakeReq)
        else $error("wake without enabled event");
    AST_CC_NO_WAKE: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
        !s.stat[EVT_BTN] && !s.stat[EVT_PF] && !s.stat[EVT_PD] && !s.stat[EVT_DLL]
        |=> !wakeReq)
        else $error("command completion alone raised wake");

    // Fields and lamps move only on a write to their own byte lane
    AST_PWR_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // RULE10
        !(wrSlot && wrStrb[LANE_HI])
        |=> $stable(slotPowerOff))
        else $error("power control moved without a write");
    AST_ATTN_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // RULE6 RULE7
        !(wrSlot && wrStrb[LANE_LO])
        |=> $stable(attnState) && !attnMsgValid)
        else $error("attention lamp moved without a write");
    AST_PIND_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // RULE8 RULE9
        !(wrSlot && wrStrb[LANE_HI])
        |=> $stable(pwrIndState) && !pwrIndMsgValid)
        else $error("power lamp moved without a write");
    AST_ATTN_NOT_RSVD: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        attnState != IND_RSVD)
        else $error("attention indicator in reserved state");

    // Remaining paths when fully enabled: button, fault and link events reach the interrupt, presence reaches wake
    AST_BTN_IRQ: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
        (s.stat[EVT_BTN] && s.slot.btnEn && s.slot.hpIntEn && s.mask[EVT_BTN])
        |=> hotplugIrq)
        else $error("button event enabled but no interrupt");
    AST_PF_IRQ: assert property (@(posedge mclk) disable iff (!rstn) // RULE2
        (s.stat[EVT_PF] && s.slot.pfEn && s.slot.hpIntEn && s.mask[EVT_PF])
        |=> hotplugIrq)
        else $error("power fault enabled but no interrupt");
    AST_PD_WAKE: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
        (s.stat[EVT_PD] && s.slot.pdEn)
        |=> wakeReq)
        else $error("presence change enabled but no wake");
    AST_DLL_IRQ: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
        (s.stat[EVT_DLL] && s.slot.dllEn && s.slot.hpIntEn && s.mask[EVT_DLL])
        |=> hotplugIrq)
        else $error("link change enabled but no interrupt");

    COV_ATTN_MSG: cover property (@(posedge mclk) disable iff (!rstn) attnMsgValid);
    COV_IRQ: cover property (@(posedge mclk) disable iff (!rstn) $rose(hotplugIrq));
    COV_PWR_OFF: cover property (@(posedge mclk) disable iff (!rstn) $rose(slotPowerOff));
    COV_WAKE: cover property (@(posedge mclk) disable iff (!rstn) $rose(wakeReq));
    COV_DECERR: cover property (@(posedge mclk) disable iff (!rstn)
        axiRsp.bvalid && axiRsp.bresp == RESP_DECERR);
endmodule

// ---- hpsc_slot_ctl_tb.sv ----
// Self-checking bench for the slot control register block
module hpsc_slot_ctl_tb
    import hpsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk;
    logic rstn;
    hpsc_axil_req_t axiReq;
    hpsc_axil_rsp_t axiRsp;
    hpsc_evt_t evt;
    logic hotplugIrq;
    logic wakeReq;
    logic slotPowerOff;
    hpsc_ind_t attnState;
    logic attnMsgValid;
    hpsc_ind_t pwrIndState;
    logic pwrIndMsgValid;
    int num_errors;
    int num_checks;
    int attnMsgs = 0;
    int pwrMsgs = 0;
    logic [1:0] attnCode = 2'h0;
    logic [1:0] pwrCode = 2'h0;
    int slotBit[5] = '{BIT_BTN_EN, BIT_PF_EN, BIT_PD_EN, BIT_CC_EN, BIT_DLL_EN};

    hpsc_slot_ctl DUT (
        .mclk(mclk),
        .rstn(rstn),
        .axiReq(axiReq),
        .axiRsp(axiRsp),
        .evt(evt),
        .hotplugIrq(hotplugIrq),
        .wakeReq(wakeReq),
        .slotPowerOff(slotPowerOff),
        .attnState(attnState),
        .attnMsgValid(attnMsgValid),
        .pwrIndState(pwrIndState),
        .pwrIndMsgValid(pwrIndMsgValid)
    );

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    // Message counters; the pulse stands one cycle, so sample every edge
    always @(posedge mclk) begin
        if (attnMsgValid === 1'b1) begin
            attnMsgs <= attnMsgs + 1;
            attnCode <= attnState;
        end
        if (pwrIndMsgValid === 1'b1) begin
            pwrMsgs <= pwrMsgs + 1;
            pwrCode <= pwrIndState;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] expResp);
        logic awOpen;
        logic wOpen;
        awOpen = 1'b1;
        wOpen = 1'b1;
        @(posedge mclk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= s;
        axiReq.bready <= 1'b1;
        while (awOpen || wOpen) begin
            @(posedge mclk);
            if (awOpen && axiRsp.awready === 1'b1) begin
                awOpen = 1'b0;
                axiReq.awvalid <= 1'b0;
            end
            if (wOpen && axiRsp.wready === 1'b1) begin
                wOpen = 1'b0;
                axiReq.wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (axiRsp.bvalid !== 1'b1);
        check("bresp", 32'(axiRsp.bresp), 32'(expResp));
        axiReq.bready <= 1'b0;
    endtask

    // Read: hold arvalid until taken, rready until rvalid seen
    task automatic rd(input logic [7:0] a, input logic [31:0] expData, input logic [1:0] expResp);
        @(posedge mclk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        do @(posedge mclk); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        do @(posedge mclk); while (axiRsp.rvalid !== 1'b1);
        check("rdata", axiRsp.rdata, expData);
        check("rresp", 32'(axiRsp.rresp), 32'(expResp));
        axiReq.rready <= 1'b0;
    endtask

    task automatic pulse(input logic [4:0] e);
        @(posedge mclk);
        evt <= hpsc_evt_t'(e);
        @(posedge mclk);
        evt <= hpsc_evt_t'(5'h00);
    endtask

    task automatic check_irq(input logic expIrq, input logic expWake);
        pause(3);
        check("hotplugIrq", 32'(hotplugIrq), 32'(expIrq));
        check("wakeReq", 32'(wakeReq), 32'(expWake));
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests take
    initial begin
        #100us;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] ctl;
        mclk = 1'b0;
        rstn = 1'b0;
        axiReq = '0;
        evt = '0;
        num_errors = 0;
        num_checks = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        pause(2);
        // Reset values
        rd(OFF_SLOT_CTL, 32'h0000_03C0, RESP_OKAY);
        check("attnState", 32'(attnState), 32'(IND_OFF));
        check("pwrIndState", 32'(pwrIndState), 32'(IND_OFF));
        check("slotPowerOff", 32'(slotPowerOff), 32'h0);
        rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
        rd(OFF_IRQ_MASK, 32'h0000_001F, RESP_OKAY);
        // Upper lane only: power bit, power lamp, link enable
        wr(OFF_SLOT_CTL, 32'hFFFF_FFFF, 4'h2, RESP_OKAY);
        rd(OFF_SLOT_CTL, 32'h0000_17C0, RESP_OKAY);
        check("slotPowerOff", 32'(slotPowerOff), 32'h1);
        check("pwrMsgs", 32'(pwrMsgs), 32'h1);
        check("attnMsgs", 32'(attnMsgs), 32'h0);
        wr(OFF_SLOT_CTL, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
        rd(OFF_SLOT_CTL, 32'h0000_17FB, RESP_OKAY);
        pause(2);
        check("attnMsgs", 32'(attnMsgs), 32'h1);
        // Reserved lamp code ignored, power back on
        wr(OFF_SLOT_CTL, 32'h0, 4'h3, RESP_OKAY);
        rd(OFF_SLOT_CTL, 32'h0000_03C0, RESP_OKAY);
        check("slotPowerOff", 32'(slotPowerOff), 32'h0);
        check("msgs", 32'(attnMsgs + pwrMsgs), 32'h2);
        // Every non-reserved lamp code on both indicators
        for (int c = 1; c <= 3; c++) begin
            ctl = (32'(c) << BIT_PIND_LO) | (32'(c) << BIT_ATTN_LO);
            wr(OFF_SLOT_CTL, ctl, 4'h3, RESP_OKAY);
            rd(OFF_SLOT_CTL, ctl, RESP_OKAY);
            check("attnState", 32'(attnState), 32'(c));
            check("pwrIndState", 32'(pwrIndState), 32'(c));
            check("attnMsg", {attnCode, 30'(attnMsgs)}, {2'(c), 30'(c + 1)});
            check("pwrMsg", {pwrCode, 30'(pwrMsgs)}, {2'(c), 30'(c + 1)});
        end
        // Unmapped and unaligned accesses
        wr(8'hDC, 32'hFFFF_FFFF, 4'hF, RESP_DECERR);
        wr(8'hD9, 32'h0, 4'hF, RESP_DECERR);
        rd(8'hD9, 32'h0, RESP_DECERR);
        rd(OFF_SLOT_CTL, 32'h0000_03C0, RESP_OKAY);
        // Each event: enable, master gate, mask, clear
        for (int i = 0; i < EVT_N; i++) begin
            ctl = 32'h3C0 | (32'h1 << slotBit[i]) | (32'h1 << BIT_HPINT_EN);
            wr(OFF_SLOT_CTL, ctl, 4'h3, RESP_OKAY);
            pulse(5'(1 << i));
            check_irq(1'b1, WAKE_EVTS[i]);
            rd(OFF_IRQ_STAT, 32'h1 << i, RESP_OKAY);
            wr(OFF_SLOT_CTL, ctl & ~(32'h1 << BIT_HPINT_EN), 4'h3, RESP_OKAY);
            check_irq(1'b0, WAKE_EVTS[i]);
            wr(OFF_SLOT_CTL, ctl, 4'h3, RESP_OKAY);
            wr(OFF_IRQ_MASK, 32'h1F & ~(32'h1 << i), 4'h1, RESP_OKAY);
            check_irq(1'b0, WAKE_EVTS[i]);
            wr(OFF_IRQ_MASK, 32'h1F, 4'h1, RESP_OKAY);
            check_irq(1'b1, WAKE_EVTS[i]);
            wr(OFF_SLOT_CTL, 32'h3E0, 4'h3, RESP_OKAY);
            check_irq(1'b0, 1'b0);
            wr(OFF_IRQ_STAT, 32'h1 << i, 4'h1, RESP_OKAY);
            rd(OFF_IRQ_STAT, 32'h0, RESP_OKAY);
        end
        tally_and_finish();
    end
endmodule
